//--- shared/sdic_pkg.sv
// Summary of operation
// - step rises move; high at least 5 us
// - direction change during step high enters command
// - direction falling while step high arms decoder
// - command mode steps need 20 us, filterable
// - command recognition five seconds, then forwarding
// - command mode requested only in first window
// - forwarding routes step and direction straight through
// - command mode accepts commands alongside stepping
// - direction high is clockwise, polarity configurable
// - six selectable step resolutions
// - resolution resets to quarter step
// - limit and estop ignored until enabled
// - limit modes off, on, smart; polarity
// - joystick rate proportional, dead band, max rate
// - joystick following off after reset
// - slave address defaults 0x14, changeable
// - commands from step lines or I2C
// - coil fault disables power until reset
// - automatic power off with idle period
// - settings saved, reloaded at power-up
package sdic_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PASS_MIN_NS = 5000;
  localparam int unsigned PASS_MIN_CYC = (PASS_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD_MIN_NS = 20000;
  localparam int unsigned CMD_MIN_CYC = (CMD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WINDOW_S = 5;
  localparam int unsigned WINDOW_CYC = WINDOW_S * CLK_MHZ * 1000000;
  localparam int unsigned MS_CYC = CLK_MHZ * 1000;
  // ==========================================================
  // values after reset
  localparam logic [6:0] I2C_ADDR_RST = 7'h14;
  localparam logic [9:0] JOY_CENTER = 10'h200;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SDIC_FULL = 3'h0,
    SDIC_WAVE = 3'h1,
    SDIC_HALF = 3'h2,
    SDIC_QUARTER = 3'h3,
    SDIC_EIGHTH = 3'h4,
    SDIC_SIXTEENTH = 3'h5
  } sdic_step_mode_t;
  typedef enum logic [1:0] {
    SDIC_LIM_OFF = 2'h0,
    SDIC_LIM_ON = 2'h1,
    SDIC_LIM_SMART = 2'h2
  } sdic_lim_t;
  typedef enum logic {
    SDIC_MODE_CMD = 1'h0,
    SDIC_MODE_PASS = 1'h1
  } sdic_mode_t;
  typedef struct packed {
    logic dir_inv;
    sdic_step_mode_t step_mode;
    sdic_lim_t lim_mode;
    logic lim_pol;
    logic estop_en;
    logic estop_pol;
    logic joy_en;
    logic [9:0] joy_db;
    logic [7:0] joy_rate;
    logic auto_off;
    logic [15:0] idle_ms;
    logic filt_en;
    logic [3:0] filt_loops;
  } sdic_cfg_t;
  typedef struct packed {
    logic fault;
    logic estop;
    logic limit;
    logic dir;
    logic step;
  } sdic_pins_t;
  localparam sdic_cfg_t CFG_RST = '{
    dir_inv: 1'h0, step_mode: SDIC_QUARTER, lim_mode: SDIC_LIM_OFF,
    lim_pol: 1'h0, estop_en: 1'h0, estop_pol: 1'h0, joy_en: 1'h0,
    joy_db: 10'h00C, joy_rate: 8'h50, auto_off: 1'h0, idle_ms: 16'h0000,
    filt_en: 1'h0, filt_loops: 4'h2};
endpackage : sdic_pkg

//--- core/sdic_sync.sv
`timescale 1ns/1ps
// ============================================================
// pin synchroniser: three stages, output moves once 2nd and 3rd agree
module sdic_sync #(
  parameter int W = 5
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // the first stage feeds only the second
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // agreement filter rejects one-cycle disagreement
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        q_o[i] <= 1'b0;
      end else if (s2[i] == s3[i]) begin
        q_o[i] <= s3[i];
      end
    end
  end
endmodule : sdic_sync

//--- core/sdic_top.sv
`timescale 1ns/1ps
module sdic_top #(
  parameter int unsigned WINDOW_CYC = sdic_pkg::WINDOW_CYC,
  parameter int unsigned MS_CYC = sdic_pkg::MS_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire sdic_pkg::sdic_pins_t pins_i,
  input wire logic [9:0] joy_sample_i,
  input wire logic joy_valid_i,
  input wire logic cfg_wr_i,
  input wire sdic_pkg::sdic_cfg_t cfg_i,
  input wire logic cmd_on_i,
  input wire logic cmd_off_i,
  input wire logic addr_wr_i,
  input wire logic [6:0] addr_i,
  input wire logic i2c_valid_i,
  input wire logic [7:0] i2c_byte_i,
  input wire logic nvm_valid_i,
  input wire sdic_pkg::sdic_cfg_t nvm_cfg_i,
  input wire logic save_i,
  output logic i2c_ready_o,
  output logic motor_step_o,
  output logic motor_dir_o,
  output logic motor_en_o,
  output sdic_pkg::sdic_step_mode_t step_mode_o,
  output logic cmd_mode_o,
  output logic window_open_o,
  output logic cmd_armed_o,
  output logic short_pulse_o,
  output logic fault_o,
  output logic cmd_valid_o,
  output logic cmd_src_o,
  output logic [7:0] cmd_byte_o,
  output logic [6:0] i2c_addr_o,
  output logic nvm_read_o,
  output logic nvm_store_o,
  output sdic_pkg::sdic_cfg_t nvm_cfg_o
);
  // ==========================================================
  // input conditioning
  sdic_pkg::sdic_pins_t pin_s;
  sdic_pkg::sdic_cfg_t cfg;
  sdic_pkg::sdic_mode_t mode;
  logic step_q, dir_q, step_rise, step_fall, dir_fall, dir_chg;
  logic [15:0] hi_cnt, need;
  logic dir_moved, win_open, win_done, keep, armed, cmd_step;
  logic [31:0] win_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic line_byte, cw, stop_now, lim_act, estop_act, lim_dir;
  logic [15:0] str_cnt;
  logic str_dir, joy_step, joy_dir, boot, fault_lat;
  logic [9:0] joy_exc;
  logic [23:0] joy_acc;
  logic [31:0] ms_cnt;
  logic [15:0] idle;

  sdic_sync #(.W(5)) u_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .d_i(pins_i),
    .q_o(pin_s)
  );

  // edges of the synchronised lines
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      step_q <= pin_s.step;
      dir_q <= pin_s.dir;
    end
  end
  assign step_rise = pin_s.step & ~step_q;
  assign step_fall = ~pin_s.step & step_q;
  assign dir_fall = ~pin_s.dir & dir_q;
  assign dir_chg = pin_s.dir ^ dir_q;

  // ==========================================================
  // pulse width and direction stability
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      hi_cnt <= 16'h0000;
    end else if (step_rise) begin
      hi_cnt <= 16'h0001;
    end else if (pin_s.step && hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
  // direction must hold through the high level
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dir_moved <= 1'b0;
    end else if (step_rise) begin
      dir_moved <= 1'b0;
    end else if (pin_s.step && dir_chg) begin
      dir_moved <= 1'b1;
    end
  end
  // filtering lengthens the accepted width by a loop count
  assign need = (cfg.filt_en && cfg.filt_loops != 4'h0)
                ? 16'(sdic_pkg::CMD_MIN_CYC * cfg.filt_loops)
                            : 16'(sdic_pkg::CMD_MIN_CYC);

  // ==========================================================
  // mode selection window
  assign win_done = win_open && (win_cnt == WINDOW_CYC - 1);
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      win_cnt <= 32'h00000000;
      win_open <= 1'b1;
    end else if (win_done) begin
      win_open <= 1'b0;
    end else if (win_open) begin
      win_cnt <= win_cnt + 32'h00000001;
    end
  end
  // a request to stay in command mode counts only inside the window
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      keep <= 1'b0;
    end else if (cmd_off_i) begin
      keep <= 1'b0;
    end else if (cmd_on_i && win_open) begin
      keep <= 1'b1;
    end
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mode <= sdic_pkg::SDIC_MODE_CMD;
    end else begin
      unique case (mode)
        sdic_pkg::SDIC_MODE_CMD: begin
          if (cmd_off_i || (win_done && !keep)) begin
            mode <= sdic_pkg::SDIC_MODE_PASS;
          end
        end
        sdic_pkg::SDIC_MODE_PASS: begin
          if (win_open && (cmd_on_i || (pin_s.step && dir_chg))) begin
            mode <= sdic_pkg::SDIC_MODE_CMD;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // embedded command bytes on the step lines
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      armed <= 1'b0;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
    end else if (mode != sdic_pkg::SDIC_MODE_CMD) begin
      armed <= 1'b0;
      bit_cnt <= 3'h0;
    end else if (!armed && pin_s.step && dir_fall) begin
      armed <= 1'b1;
      bit_cnt <= 3'h0;
    end else if (armed && step_rise) begin
      shreg <= {shreg[6:0], pin_s.dir};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        armed <= 1'b0;
      end
    end
  end
  assign line_byte = armed && step_rise && bit_cnt == 3'h7;
  // line bytes win; the I2C source is stalled in that cycle
  assign i2c_ready_o = ~line_byte;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_valid_o <= 1'b0;
      cmd_src_o <= 1'b0;
      cmd_byte_o <= 8'h00;
    end else begin
      cmd_valid_o <= line_byte || i2c_valid_i;
      if (line_byte) begin
        cmd_src_o <= 1'b0;
        cmd_byte_o <= {shreg[6:0], pin_s.dir};
      end else if (i2c_valid_i) begin
        cmd_src_o <= 1'b1;
        cmd_byte_o <= i2c_byte_i;
      end
    end
  end
  // a qualified step in command mode is issued at the falling edge
  assign cmd_step = (mode == sdic_pkg::SDIC_MODE_CMD) && step_fall && !armed
                    && !dir_moved && hi_cnt >= need;
  // too-short pulses in forwarding mode are flagged, still forwarded
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      short_pulse_o <= 1'b0;
    end else begin
      short_pulse_o <= step_fall && mode == sdic_pkg::SDIC_MODE_PASS
                       && hi_cnt < 16'(sdic_pkg::PASS_MIN_CYC);
    end
  end

  // ==========================================================
  // limit and emergency stop
  function automatic logic blocks(input logic go_cw, input logic l_act,
                                  input logic e_act, input logic l_dir,
                                  input sdic_pkg::sdic_lim_t lm);
    blocks = e_act || (l_act && (lm == sdic_pkg::SDIC_LIM_ON
             || (lm == sdic_pkg::SDIC_LIM_SMART && go_cw == l_dir)));
  endfunction : blocks
  assign lim_act = (pin_s.limit ^ cfg.lim_pol) && cfg.lim_mode != sdic_pkg::SDIC_LIM_OFF;
  assign estop_act = (pin_s.estop ^ cfg.estop_pol) && cfg.estop_en;
  assign cw = pin_s.dir ^ cfg.dir_inv;
  assign stop_now = blocks(cw, lim_act, estop_act, lim_dir, cfg.lim_mode);
  // smart mode remembers the heading that ran into the switch
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      lim_dir <= 1'b0;
    end else if (!lim_act) begin
      lim_dir <= motor_dir_o;
    end
  end

  // ==========================================================
  // joystick rate generator
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      joy_exc <= 10'h000;
      joy_dir <= 1'b0;
    end else if (!cfg.joy_en) begin
      joy_exc <= 10'h000;
    end else if (joy_valid_i) begin
      joy_dir <= joy_sample_i >= sdic_pkg::JOY_CENTER;
      if (joy_sample_i >= sdic_pkg::JOY_CENTER) begin
        joy_exc <= (joy_sample_i - sdic_pkg::JOY_CENTER > cfg.joy_db)
                   ? joy_sample_i - sdic_pkg::JOY_CENTER - cfg.joy_db : 10'h000;
      end else begin
        joy_exc <= (sdic_pkg::JOY_CENTER - joy_sample_i > cfg.joy_db)
                   ? sdic_pkg::JOY_CENTER - joy_sample_i - cfg.joy_db : 10'h000;
      end
    end
  end
  // phase accumulator: rate follows offset times the programmed maximum
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      joy_acc <= 24'h000000;
      joy_step <= 1'b0;
    end else begin
      {joy_step, joy_acc} <= {1'b0, joy_acc} + 25'(joy_exc * cfg.joy_rate);
    end
  end

  // ==========================================================
  // step output and pulse stretcher
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      str_cnt <= 16'h0000;
      str_dir <= 1'b0;
    end else if (str_cnt != 16'h0000) begin
      str_cnt <= str_cnt - 16'h0001;
    end else if (cmd_step && !stop_now) begin
      str_cnt <= 16'(sdic_pkg::PASS_MIN_CYC);
      str_dir <= cw;
    end else if (joy_step && cfg.joy_en && !pin_s.step
                 && !blocks(joy_dir, lim_act, estop_act, lim_dir, cfg.lim_mode)) begin
      str_cnt <= 16'(sdic_pkg::PASS_MIN_CYC);
      str_dir <= joy_dir;
    end
  end
  // forwarding passes the line through; stretched pulses hold direction
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      motor_step_o <= 1'b0;
      motor_dir_o <= 1'b0;
    end else if (str_cnt != 16'h0000) begin
      motor_step_o <= 1'b1;
      motor_dir_o <= str_dir;
    end else if (mode == sdic_pkg::SDIC_MODE_PASS) begin
      motor_step_o <= pin_s.step && !stop_now;
      motor_dir_o <= cw;
    end else begin
      motor_step_o <= 1'b0;
      motor_dir_o <= cw;
    end
  end

  // ==========================================================
  // power stage enable: fault latch and idle shut-off
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fault_lat <= 1'b0;
    end else if (pin_s.fault) begin
      fault_lat <= 1'b1;
    end
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ms_cnt <= 32'h00000000;
      idle <= 16'h0000;
    end else if (motor_step_o) begin
      ms_cnt <= 32'h00000000;
      idle <= 16'h0000;
    end else if (ms_cnt == MS_CYC - 1) begin
      ms_cnt <= 32'h00000000;
      if (idle != 16'hFFFF) begin
        idle <= idle + 16'h0001;
      end
    end else begin
      ms_cnt <= ms_cnt + 32'h00000001;
    end
  end
  assign motor_en_o = !fault_lat && !(cfg.auto_off && idle >= cfg.idle_ms);
  assign fault_o = fault_lat;

  // ==========================================================
  // settings, address and non-volatile store
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= sdic_pkg::CFG_RST;
    end else if (cfg_wr_i) begin
      cfg <= cfg_i;
    end else if (nvm_valid_i) begin
      cfg <= nvm_cfg_i;
    end
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      i2c_addr_o <= sdic_pkg::I2C_ADDR_RST;
    end else if (addr_wr_i) begin
      i2c_addr_o <= addr_i;
    end
  end
  // one read request right after reset reloads the stored settings
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      boot <= 1'b1;
      nvm_read_o <= 1'b0;
      nvm_store_o <= 1'b0;
      nvm_cfg_o <= sdic_pkg::CFG_RST;
    end else begin
      boot <= 1'b0;
      nvm_read_o <= boot;
      nvm_store_o <= save_i;
      if (save_i) begin
        nvm_cfg_o <= cfg;
      end
    end
  end
  assign step_mode_o = cfg.step_mode;
  assign cmd_mode_o = mode == sdic_pkg::SDIC_MODE_CMD;
  assign window_open_o = win_open;
  assign cmd_armed_o = armed;

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  pass_route_a: assert property ((mode == sdic_pkg::SDIC_MODE_PASS && str_cnt == 16'h0000
    && step_rise && !stop_now) |=> motor_step_o) else $error("forwarded step missing");
  dir_pol_a: assert property ((!cfg.dir_inv && str_cnt == 16'h0000) |=>
    motor_dir_o == $past(pin_s.dir)) else $error("direction polarity wrong");
  win_close_a: assert property ((mode == sdic_pkg::SDIC_MODE_CMD && win_done && !keep)
    |=> mode == sdic_pkg::SDIC_MODE_PASS) else $error("window close ignored");
  late_req_a: assert property ((!win_open && mode == sdic_pkg::SDIC_MODE_PASS)
    |=> mode == sdic_pkg::SDIC_MODE_PASS) else $error("late command mode entry");
  cmd_arm_a: assert property ((mode == sdic_pkg::SDIC_MODE_CMD && !armed && pin_s.step
    && dir_fall) |=> armed && !cmd_step) else $error("arm not taken");
  cmd_width_a: assert property (cmd_step |-> hi_cnt >= 16'(sdic_pkg::CMD_MIN_CYC)
    && !dir_moved) else $error("short command step accepted");
  step_hold_a: assert property ((cmd_step && !stop_now && str_cnt == 16'h0000)
    |=> ##1 motor_step_o [*8]) else $error("step pulse too short");
  fault_hold_a: assert property (fault_lat |=> fault_lat && !motor_en_o)
    else $error("power stage back on after fault");
  joy_off_a: assert property (!cfg.joy_en |=> joy_exc == 10'h000)
    else $error("joystick active while disabled");
endmodule : sdic_top

//--- verif/sdic_ctl_model.sv
`timescale 1ns/1ps
// ==========================================================
// motion controller model driving the step, direction and switch pins
module sdic_ctl_model (
  input wire logic clock_i,
  output sdic_pkg::sdic_pins_t pins_o
);
  initial pins_o = '0;
  // pins move just after an edge, never on it
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc
  // one step; flip breaks the hold only where a test asks for it
  task automatic step(input logic dir, input int hi, input logic flip);
    pins_o.dir = dir; // settled before the rise
    wait_cyc(20);
    pins_o.step = 1'b1;
    wait_cyc(hi / 2); // width chosen by the caller
    pins_o.dir = dir ^ flip; // held while high unless flip
    wait_cyc(hi - hi / 2);
    pins_o.step = 1'b0;
    wait_cyc(20);
  endtask : step
  // line byte: direction falls under a high step, then msb first
  task automatic send_byte(input logic [7:0] b);
    step(1'b1, 40, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      step(b[i], 20, 1'b0);
    end
  endtask : send_byte
  // switch lines, active high with default polarity
  task automatic set_sw(input logic fault, input logic estop, input logic limit);
    pins_o.fault = fault;
    pins_o.estop = estop;
    pins_o.limit = limit;
    wait_cyc(10);
  endtask : set_sw
endmodule : sdic_ctl_model

//--- verif/step_direction_input_control_tb.sv
`timescale 1ns/1ps
module step_direction_input_control_tb;
  localparam int unsigned WIN = 20000;
  localparam int unsigned MS = 50;
  typedef struct packed {
    sdic_pkg::sdic_step_mode_t mode;
    logic [2:0] exp;
  } sdic_row_t;
  sdic_row_t rows [6] = '{'{sdic_pkg::SDIC_FULL, 3'h0}, '{sdic_pkg::SDIC_WAVE, 3'h1},
    '{sdic_pkg::SDIC_HALF, 3'h2}, '{sdic_pkg::SDIC_QUARTER, 3'h3},
    '{sdic_pkg::SDIC_EIGHTH, 3'h4}, '{sdic_pkg::SDIC_SIXTEENTH, 3'h5}};
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  sdic_pkg::sdic_pins_t pins;
  logic [9:0] joy_sample_i = 10'h200;
  logic joy_valid_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  sdic_pkg::sdic_cfg_t cfg_i = sdic_pkg::CFG_RST;
  sdic_pkg::sdic_cfg_t c;
  logic cmd_on_i = 1'b0;
  logic cmd_off_i = 1'b0;
  logic addr_wr_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic i2c_valid_i = 1'b0;
  logic [7:0] i2c_byte_i = 8'h00;
  logic nvm_valid_i = 1'b0;
  sdic_pkg::sdic_cfg_t nvm_cfg_i = sdic_pkg::CFG_RST;
  logic save_i = 1'b0;
  logic i2c_ready_o, motor_step_o, motor_dir_o, motor_en_o, cmd_mode_o, window_open_o;
  logic cmd_armed_o, short_pulse_o, fault_o, cmd_valid_o, cmd_src_o, nvm_read_o, nvm_store_o;
  sdic_pkg::sdic_step_mode_t step_mode_o;
  logic [7:0] cmd_byte_o;
  logic [6:0] i2c_addr_o;
  sdic_pkg::sdic_cfg_t nvm_cfg_o;
  int mismatches = 0;
  int n_checks = 0;
  int n_steps = 0;
  int n_short = 0;
  int n_cmds = 0;
  int n_busy = 0;
  int n_arm = 0;
  int cyc = 0;
  int n0;
  logic step_q = 1'b0;
  logic last_dir = 1'b0;
  logic last_src = 1'b0;
  logic [7:0] last_byte = 8'h00;

  // ==========================================================
  // clock, device and controller model
  always #5 clock_i = ~clock_i;
  sdic_top #(.WINDOW_CYC(WIN), .MS_CYC(MS)) dut (.clock_i(clock_i), .reset_i(reset_i),
    .pins_i(pins), .joy_sample_i(joy_sample_i), .joy_valid_i(joy_valid_i),
    .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .cmd_on_i(cmd_on_i), .cmd_off_i(cmd_off_i),
    .addr_wr_i(addr_wr_i), .addr_i(addr_i), .i2c_valid_i(i2c_valid_i),
    .i2c_byte_i(i2c_byte_i), .nvm_valid_i(nvm_valid_i), .nvm_cfg_i(nvm_cfg_i),
    .save_i(save_i), .i2c_ready_o(i2c_ready_o), .motor_step_o(motor_step_o),
    .motor_dir_o(motor_dir_o), .motor_en_o(motor_en_o), .step_mode_o(step_mode_o),
    .cmd_mode_o(cmd_mode_o), .window_open_o(window_open_o), .cmd_armed_o(cmd_armed_o),
    .short_pulse_o(short_pulse_o), .fault_o(fault_o), .cmd_valid_o(cmd_valid_o),
    .cmd_src_o(cmd_src_o), .cmd_byte_o(cmd_byte_o), .i2c_addr_o(i2c_addr_o),
    .nvm_read_o(nvm_read_o), .nvm_store_o(nvm_store_o), .nvm_cfg_o(nvm_cfg_o));
  sdic_ctl_model ctl (.clock_i(clock_i), .pins_o(pins));

  // output monitor: motor steps counted once per rising edge; busy and armed cycles counted one by one
  always @(posedge clock_i) begin
    cyc <= reset_i ? 0 : cyc + 1;
    step_q <= motor_step_o;
    if (motor_step_o === 1'b1 && step_q === 1'b0) begin
      n_steps <= n_steps + 1;
      last_dir <= motor_dir_o;
    end
    if (short_pulse_o === 1'b1) n_short <= n_short + 1;
    if (i2c_ready_o === 1'b0) n_busy <= n_busy + 1;
    if (cmd_armed_o === 1'b1) n_arm <= n_arm + 1;
    if (cmd_valid_o === 1'b1) begin
      n_cmds <= n_cmds + 1;
      last_byte <= cmd_byte_o;
      last_src <= cmd_src_o;
    end
  end

  // ==========================================================
  // helpers
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask : tick
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val
  task automatic write_cfg(input sdic_pkg::sdic_cfg_t v);
    cfg_i = v;
    cfg_wr_i = 1'b1;
    tick();
    cfg_wr_i = 1'b0;
    tick();
  endtask : write_cfg
  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask : end_test
  // bounded wait for the mode window; running out counts as a mismatch
  task automatic wait_win();
    for (int i = 0; i < 30000 && window_open_o !== 1'b0; i++) tick();
    if (window_open_o !== 1'b0) mismatches++;
    check_val(cyc >= WIN - 2 && cyc <= WIN + 2, 1'b1);
  endtask : wait_win
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    check_val(i2c_addr_o, 7'h14);
    check_val({cmd_mode_o, window_open_o}, 2'h3);
    check_val(step_mode_o, 3'h3);
    check_val({motor_en_o, fault_o}, 2'h2);
    tick();
    check_val(nvm_read_o, 1'b1);
    end_test("reset");
    foreach (rows[i]) begin
      c = sdic_pkg::CFG_RST;
      c.step_mode = rows[i].mode;
      write_cfg(c);
      check_val(step_mode_o, rows[i].exp);
    end
    write_cfg(sdic_pkg::CFG_RST);
    end_test("resolution");
    n0 = n_steps;
    ctl.step(1'b1, 2100, 1'b0);
    check_val({n_steps - n0, last_dir}, {32'd1, 1'b1});
    ctl.step(1'b1, 600, 1'b0);
    check_val(n_steps - n0, 1);
    c = sdic_pkg::CFG_RST;
    c.filt_en = 1'b1;
    write_cfg(c);
    ctl.step(1'b1, 2100, 1'b0);
    check_val(n_steps - n0, 1);
    write_cfg(sdic_pkg::CFG_RST);
    end_test("command step");
    ctl.send_byte(8'hA5);
    check_val({n_cmds, last_byte, last_src}, {32'd1, 8'hA5, 1'b0});
    check_val(n_steps - n0, 1);
    check_val({n_busy, n_arm != 0, cmd_armed_o}, {32'd1, 1'b1, 1'b0});
    i2c_byte_i = 8'h3C;
    i2c_valid_i = 1'b1;
    tick();
    i2c_valid_i = 1'b0;
    repeat (2) tick();
    check_val({n_cmds, last_byte, last_src}, {32'd2, 8'h3C, 1'b1});
    addr_i = 7'h2B;
    addr_wr_i = 1'b1;
    tick();
    addr_wr_i = 1'b0;
    check_val(i2c_addr_o, 7'h2B);
    end_test("commands");
    save_i = 1'b1;
    tick();
    save_i = 1'b0;
    check_val({nvm_store_o, nvm_cfg_o}, {1'b1, sdic_pkg::CFG_RST});
    tick();
    check_val(nvm_store_o, 1'b0);
    c = sdic_pkg::CFG_RST;
    c.step_mode = sdic_pkg::SDIC_EIGHTH;
    nvm_cfg_i = c;
    nvm_valid_i = 1'b1;
    tick();
    nvm_valid_i = 1'b0;
    check_val(step_mode_o, 3'h4);
    end_test("storage");
    // joystick: off by default, still inside the dead band, stepping at full deflection
    joy_valid_i = 1'b1;
    joy_sample_i = 10'h3FF;
    repeat (1500) tick();
    check_val(n_steps - n0, 1);
    c.joy_en = 1'b1;
    write_cfg(c);
    joy_sample_i = 10'h205;
    repeat (1500) tick();
    check_val(n_steps - n0, 1);
    joy_sample_i = 10'h3FF;
    repeat (3000) tick();
    check_val(n_steps - n0 > 1, 1'b1);
    joy_valid_i = 1'b0;
    joy_sample_i = 10'h200;
    write_cfg(sdic_pkg::CFG_RST);
    repeat (600) tick();
    end_test("joystick");
    wait_win();
    tick();
    check_val(cmd_mode_o, 1'b0);
    cmd_on_i = 1'b1;
    tick();
    cmd_on_i = 1'b0;
    ctl.step(1'b1, 600, 1'b1);
    check_val(cmd_mode_o, 1'b0);
    end_test("window");
    n0 = n_steps;
    ctl.step(1'b1, 200, 1'b0);
    check_val({n_steps - n0, n_short, last_dir}, {32'd1, 32'd1, 1'b1});
    c = sdic_pkg::CFG_RST;
    c.dir_inv = 1'b1;
    write_cfg(c);
    ctl.step(1'b1, 600, 1'b0);
    check_val({n_steps - n0, last_dir}, {32'd2, 1'b0});
    write_cfg(sdic_pkg::CFG_RST);
    ctl.set_sw(1'b0, 1'b1, 1'b0);
    ctl.step(1'b1, 600, 1'b0);
    check_val(n_steps - n0, 3);
    c = sdic_pkg::CFG_RST;
    c.estop_en = 1'b1;
    write_cfg(c);
    ctl.step(1'b1, 600, 1'b0);
    check_val(n_steps - n0, 3);
    ctl.set_sw(1'b0, 1'b0, 1'b1);
    for (int m = 0; m < 3; m++) begin
      c = sdic_pkg::CFG_RST;
      c.lim_mode = sdic_pkg::sdic_lim_t'(m);
      write_cfg(c);
      n0 = n_steps;
      ctl.step(1'b1, 600, 1'b0);
      check_val(n_steps - n0, m == 0);
    end
    ctl.step(1'b0, 600, 1'b0);
    check_val(n_steps - n0, 1);
    end_test("forwarding");
    c = sdic_pkg::CFG_RST;
    c.auto_off = 1'b1;
    c.idle_ms = 16'h0002;
    write_cfg(c);
    repeat (150) tick();
    check_val(motor_en_o, 1'b0);
    write_cfg(sdic_pkg::CFG_RST);
    ctl.set_sw(1'b1, 1'b0, 1'b0);
    ctl.set_sw(1'b0, 1'b0, 1'b0);
    check_val({fault_o, motor_en_o}, 2'h2);
    end_test("power");
    // second power cycle: fault clears, a request in the window is kept
    reset_i = 1'b1;
    repeat (6) tick();
    reset_i = 1'b0;
    check_val({fault_o, motor_en_o, cmd_mode_o, window_open_o}, 4'h7);
    cmd_off_i = 1'b1;
    tick();
    cmd_off_i = 1'b0;
    check_val({nvm_read_o, cmd_mode_o}, 2'h2);
    ctl.step(1'b1, 600, 1'b1);
    check_val(cmd_mode_o, 1'b1);
    cmd_on_i = 1'b1;
    tick();
    cmd_on_i = 1'b0;
    wait_win();
    check_val(cmd_mode_o, 1'b1);
    cmd_off_i = 1'b1;
    tick();
    cmd_off_i = 1'b0;
    check_val(cmd_mode_o, 1'b0);
    end_test("restart");
    stop_test();
  end
endmodule : step_direction_input_control_tb
